//--- common/cfb_pkg.sv
// shared constants and types for the filter 8-11 buffer pointer register
`default_nettype none
package cfb_pkg;
   // ==========================================================
   // register map
   localparam logic [31:0] CFB_SELECT_ADDR = 32'h0000_0000;
   localparam logic [15:0] CFB_SELECT_RESET = 16'h0000;
   localparam int CFB_FIELD_W = 4;
   localparam int CFB_NUM_FILTERS = 4;
   localparam logic [3:0] CFB_FIRST_FILTER = 4'h8;
   // field positions (low bit of each field)
   localparam int CFB_F8_LSB = 0;
   localparam int CFB_F9_LSB = 4;
   localparam int CFB_F10_LSB = 8;
   localparam int CFB_F11_LSB = 12;
   localparam logic [3:0] CFB_FIFO_CODE = 4'hF;
   // ==========================================================
   // ahb-lite encodings
   localparam logic [1:0] CFB_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] CFB_HTRANS_SEQ = 2'h3;
   localparam logic [2:0] CFB_HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {CFB_NOHIT, CFB_HIT} cfb_hit_e;

   // routed destination for one accepted message
   typedef struct packed {
      logic valid;
      logic to_fifo;
      logic [3:0] buffer;
      logic [3:0] filter;
   } cfb_route_s;

   // ahb-lite address phase captured by the slave
   typedef struct packed {
      logic write;
      logic sel_ok;
   } cfb_aphase_s;
endpackage : cfb_pkg
`default_nettype wire

//--- hdl/cfb_field_decode.sv
// decode of one 4-bit destination field into buffer or fifo
`default_nettype none
module cfb_field_decode
(
   input wire logic [3:0] field,
   output logic to_fifo,
   output logic [3:0] buffer
);
   import cfb_pkg::*;
   // ==========================================================
   // decode
   always_comb
   begin
      to_fifo = (field == CFB_FIFO_CODE);
      buffer = to_fifo ? 4'h0 : field;
   end
endmodule : cfb_field_decode
`default_nettype wire

//--- hdl/cfb_ahb_slave.sv
// ahb-lite single-register slave for the 16-bit pointer register
`default_nettype none
module cfb_ahb_slave
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [15:0] reg_value,
   output logic [31:0] hrdata
);
   import cfb_pkg::*;
   cfb_aphase_s aphase;
   cfb_aphase_s next_aphase;
   logic [15:0] next_reg_value;
   logic [31:0] next_hrdata;
   logic accept;

   // ==========================================================
   // address phase capture, zero wait states
   always_comb
   begin
      accept = hsel && hready && (htrans == CFB_HTRANS_NONSEQ || htrans == CFB_HTRANS_SEQ);
      next_aphase.write = accept && hwrite;
      next_aphase.sel_ok = accept && (haddr == CFB_SELECT_ADDR) && (hsize == CFB_HSIZE_WORD);
      next_reg_value = reg_value;
      if (aphase.write && aphase.sel_ok)
      begin
         next_reg_value = hwdata[15:0];
      end
      // unmapped reads return zero; upper bits read zero
      next_hrdata = hrdata;
      if (accept && !hwrite)
      begin
         next_hrdata = (next_aphase.sel_ok) ? {16'h0000, next_reg_value} : 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         aphase <= '0;
         reg_value <= CFB_SELECT_RESET;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         aphase <= next_aphase;
         reg_value <= next_reg_value;
         hrdata <= next_hrdata;
      end
   end
endmodule : cfb_ahb_slave
`default_nettype wire

//--- hdl/cfb_top.sv
// filter 8-11 buffer pointer register with hit routing
`default_nettype none
module cfb_top
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [3:0] filter_hit,
   output cfb_pkg::cfb_route_s route,
   output logic [15:0] filter_8_11_buffer_select
);
   import cfb_pkg::*;
   logic [15:0] reg_value;
   logic [3:0] field_fifo;
   logic [3:0] field_buf [CFB_NUM_FILTERS];
   logic [3:0] field_val [CFB_NUM_FILTERS];
   cfb_route_s next_route;

   // ==========================================================
   // register access
   cfb_ahb_slave u_slave
   (
      .mclk(mclk),
      .nrst(nrst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .reg_value(reg_value),
      .hrdata(hrdata)
   );

   // ==========================================================
   // field split and decode
   // field layout within the register
   assign field_val[0] = reg_value[CFB_F8_LSB +: CFB_FIELD_W];
   assign field_val[1] = reg_value[CFB_F9_LSB +: CFB_FIELD_W];
   assign field_val[2] = reg_value[CFB_F10_LSB +: CFB_FIELD_W];
   assign field_val[3] = reg_value[CFB_F11_LSB +: CFB_FIELD_W];

   // one decoder per filter, same encoding
   generate
      for (genvar i = 0; i < CFB_NUM_FILTERS; i++)
      begin : g_dec
         cfb_field_decode u_dec
         (
            .field(field_val[i]),
            .to_fifo(field_fifo[i]),
            .buffer(field_buf[i])
         );
      end
   endgenerate

   // ==========================================================
   // routing of a hit; lowest filter wins if several hit at once
   always_comb
   begin
      next_route = '0;
      for (int i = CFB_NUM_FILTERS - 1; i >= 0; i--)
      begin
         if (filter_hit[i])
         begin
            next_route.valid = 1'b1;
            next_route.to_fifo = field_fifo[i];
            next_route.buffer = field_buf[i];
            next_route.filter = CFB_FIRST_FILTER + 4'(i);
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         route <= '0;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         filter_8_11_buffer_select <= CFB_SELECT_RESET;
      end
      else
      begin
         route <= next_route;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         filter_8_11_buffer_select <= reg_value;
      end
   end

   // ==========================================================
   // checks
   a_reset_zero: assert property (@(posedge mclk) !nrst |=> reg_value == 16'h0000)
      else $error("register not cleared by reset");
   a_write_store: assert property (@(posedge mclk) disable iff (!nrst)
      (hsel && hready && htrans == CFB_HTRANS_NONSEQ && hwrite && haddr == CFB_SELECT_ADDR
       && hsize == CFB_HSIZE_WORD) ##1 nrst |=> reg_value == $past(hwdata[15:0]))
      else $error("write data not stored");
   a_f8_route: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h1 |=> route.valid && route.filter == 4'h8
      && (route.to_fifo ? $past(reg_value[3:0]) == 4'hF : route.buffer == $past(reg_value[3:0])))
      else $error("filter 8 routed wrongly");
   a_f9_route: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h2 |=> route.filter == 4'h9
      && (route.to_fifo ? $past(reg_value[7:4]) == 4'hF : route.buffer == $past(reg_value[7:4])))
      else $error("filter 9 routed wrongly");
   a_fifo_code: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h8 && reg_value[15:12] == 4'hF |=> route.to_fifo)
      else $error("all ones did not route to fifo");
   a_buf_code: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h4 && reg_value[11:8] != 4'hF |=> !route.to_fifo && route.buffer == $past(reg_value[11:8]))
      else $error("buffer index mismatch");
   a_f11_route: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h8 |=> route.valid && route.filter == 4'hB)
      else $error("filter 11 not applied");
   a_read_back: assert property (@(posedge mclk) disable iff (!nrst)
      hsel && hready && htrans == CFB_HTRANS_NONSEQ && !hwrite && haddr == CFB_SELECT_ADDR
      && hsize == CFB_HSIZE_WORD |=> hrdata == {16'h0000, reg_value})
      else $error("read data wrong");

   // ==========================================================
   // route checks, field by field and for several hits at once
   // the stimulus walks every code through every field, so each
   // field gets both the fifo code and a plain buffer index

   a_f8_fifo: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h1 && reg_value[3:0] == CFB_FIFO_CODE
      |=> route.valid && route.to_fifo && route.buffer == 4'h0)
      else $error("filter 8 fifo code not honoured");

   a_f9_fifo: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h2 && reg_value[7:4] == CFB_FIFO_CODE
      |=> route.valid && route.to_fifo && route.buffer == 4'h0)
      else $error("filter 9 fifo code not honoured");

   a_f10_fifo: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h4 && reg_value[11:8] == CFB_FIFO_CODE
      |=> route.valid && route.to_fifo && route.buffer == 4'h0)
      else $error("filter 10 fifo code not honoured");

   // filter 11 fifo only on all ones
   a_f11_fifo: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h8
      |=> route.to_fifo == ($past(reg_value[15:12]) == CFB_FIFO_CODE))
      else $error("filter 11 fifo decision wrong");

   a_f8_buffer: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h1 && reg_value[3:0] != CFB_FIFO_CODE
      |=> !route.to_fifo && route.buffer == $past(reg_value[3:0]))
      else $error("filter 8 buffer index wrong");

   a_f9_buffer: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h2 && reg_value[7:4] != CFB_FIFO_CODE
      |=> !route.to_fifo && route.buffer == $past(reg_value[7:4]))
      else $error("filter 9 buffer index wrong");

   a_f11_buffer: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h8 && reg_value[15:12] != CFB_FIFO_CODE
      |=> !route.to_fifo && route.buffer == $past(reg_value[15:12]))
      else $error("filter 11 buffer index wrong");

   a_f10_route: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h4 |=> route.valid && route.filter == 4'hA)
      else $error("filter 10 not applied");

   a_f10_prio: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'hC |=> route.valid && route.filter == 4'hA)
      else $error("filter 10 lost to filter 11");

   // filter 8 beats every other hit
   a_low_prio: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit[0] |=> route.valid && route.filter == 4'h8)
      else $error("filter 8 not given priority");

   a_f9_prio: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h6 |=> route.valid && route.filter == 4'h9)
      else $error("filter 9 lost to filter 10");

   a_hit_valid: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit != 4'h0 |=> route.valid)
      else $error("hit produced no route");

   a_no_hit: assert property (@(posedge mclk) disable iff (!nrst)
      filter_hit == 4'h0 |=> !route.valid)
      else $error("route without a hit");

   a_fifo_buf_zero: assert property (@(posedge mclk) disable iff (!nrst)
      route.to_fifo |-> route.valid && route.buffer == 4'h0)
      else $error("fifo route with buffer index");

   a_idle_route: assert property (@(posedge mclk) disable iff (!nrst)
      !route.valid |-> route == '0)
      else $error("stale fields on idle route");

   // only filters 8 to 11 reported
   a_filter_range: assert property (@(posedge mclk) disable iff (!nrst)
      route.valid |-> route.filter >= 4'h8 && route.filter <= 4'hB)
      else $error("route names a foreign filter");

   // ==========================================================
   // bus checks
   // zero wait states: a master that waits on ready never stalls

   a_ready_high: assert property (@(posedge mclk) disable iff (!nrst)
      nrst |=> hreadyout)
      else $error("ready low outside reset");

   a_resp_okay: assert property (@(posedge mclk) disable iff (!nrst)
      nrst |=> !hresp)
      else $error("error response given");

   a_read_upper: assert property (@(posedge mclk) disable iff (!nrst)
      nrst |=> hrdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");

   a_unmapped_read: assert property (@(posedge mclk) disable iff (!nrst)
      hsel && hready && htrans == CFB_HTRANS_NONSEQ && !hwrite && haddr != CFB_SELECT_ADDR
      |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_refused_size: assert property (@(posedge mclk) disable iff (!nrst)
      (hsel && hready && htrans == CFB_HTRANS_NONSEQ && hwrite && hsize != CFB_HSIZE_WORD)
      ##1 1'b1 |=> reg_value == $past(reg_value))
      else $error("narrow write changed register");

   a_refused_addr: assert property (@(posedge mclk) disable iff (!nrst)
      (hsel && hready && htrans == CFB_HTRANS_NONSEQ && hwrite && haddr != CFB_SELECT_ADDR)
      ##1 1'b1 |=> reg_value == $past(reg_value))
      else $error("unmapped write changed register");

   a_copy_reg: assert property (@(posedge mclk) disable iff (!nrst)
      nrst |=> filter_8_11_buffer_select == $past(reg_value))
      else $error("register copy out of step");

   // ==========================================================
   // reset checks
   // no disable here: these look at the reset cycles themselves

   a_reset_route: assert property (@(posedge mclk)
      !nrst |=> route == '0 && !hreadyout && !hresp)
      else $error("outputs active in reset");

   a_reset_copy: assert property (@(posedge mclk)
      !nrst |=> filter_8_11_buffer_select == 16'h0000)
      else $error("register copy not cleared");

   c_write: cover property (@(posedge mclk) hsel && htrans == CFB_HTRANS_NONSEQ && hwrite);
   c_read: cover property (@(posedge mclk) hsel && htrans == CFB_HTRANS_NONSEQ && !hwrite);
   c_fifo: cover property (@(posedge mclk) route.valid && route.to_fifo);
   c_buf14: cover property (@(posedge mclk) route.valid && route.buffer == 4'hE);
   c_multi_hit: cover property (@(posedge mclk) filter_hit == 4'hC ##1 route.valid);
endmodule : cfb_top
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the filter 8-11 buffer pointer register
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cfb_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = CFB_HSIZE_WORD;
   logic [3:0] filter_hit = 4'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   cfb_route_s route;
   logic [15:0] filter_8_11_buffer_select;
   logic [31:0] rd;
   logic [3:0] fld;
   logic [15:0] pats [3] = '{16'hFFFF, 16'h0000, 16'h5A3C};
   int fails = 0;
   int checks = 0;

   always #10 mclk = ~mclk;

   // single slave, so its ready is the bus ready
   cfb_top uut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .filter_hit(filter_hit), .route(route),
      .filter_8_11_buffer_select(filter_8_11_buffer_select));

   // ==========================================================
   // report and compare
   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask : chk

   // ==========================================================
   // bus and hit drivers
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            fails++;
            test_done();
         end
         @(posedge mclk);
      end
   endtask : wait_ready

   task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      htrans <= CFB_HTRANS_NONSEQ;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : bus

   // expected route built from the field value, fifo code gives buffer 0
   task automatic hit(input logic [3:0] h, input logic [3:0] f, input logic [3:0] v);
      filter_hit <= h;
      @(posedge mclk);
      filter_hit <= 4'h0;
      @(posedge mclk);
      chk("route", {22'h0, 1'b1, v == CFB_FIFO_CODE, (v == CFB_FIFO_CODE) ? 4'h0 : v, f}, 32'(route));
      @(posedge mclk);
      chk("valid pulse", 32'h0, {31'h0, route.valid});
   endtask : hit

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      chk("copy", 32'h0, {16'h0, filter_8_11_buffer_select});
      bus(CFB_SELECT_ADDR, 1'b0, CFB_HSIZE_WORD, 32'h0);
      chk("reset", {16'h0, CFB_SELECT_RESET}, rd);
      hit(4'h8, 4'hB, 4'h0);
      for (int i = 0; i < 3; i++)
      begin
         bus(CFB_SELECT_ADDR, 1'b1, CFB_HSIZE_WORD, {16'hFFFF, pats[i]});
         bus(CFB_SELECT_ADDR, 1'b0, CFB_HSIZE_WORD, 32'h0);
         chk("readback", {16'h0, pats[i]}, rd);
         chk("copy", {16'h0, pats[i]}, {16'h0, filter_8_11_buffer_select});
      end
      // distinct value per field, so a swapped field shows up
      for (int v = 0; v < 16; v++)
      begin
         fld = 4'(v);
         bus(CFB_SELECT_ADDR, 1'b1, CFB_HSIZE_WORD, {16'h0, fld + 4'h3, fld + 4'h2, fld + 4'h1, fld});
         for (int i = 0; i < 4; i++)
            hit(4'h1 << i, CFB_FIRST_FILTER + 4'(i), fld + 4'(i));
      end
      hit(4'hC, 4'hA, 4'h1);
      hit(4'hF, 4'h8, 4'hF);
      hit(4'h6, 4'h9, 4'h0);
      bus(32'h4, 1'b1, CFB_HSIZE_WORD, 32'hFFFF_FFFF);
      bus(CFB_SELECT_ADDR, 1'b1, 3'h1, 32'h0);
      bus(CFB_SELECT_ADDR, 1'b0, CFB_HSIZE_WORD, 32'h0);
      chk("refused", 32'h210F, rd);
      bus(32'h4, 1'b0, CFB_HSIZE_WORD, 32'h0);
      chk("unmapped", 32'h0, rd);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
